/* hdl/clfd_loop_filter.sv */
// Purpose: digital loop filter and ring fine-adjust dither
// Assumes: band code and done strobe come from the analog comparator domain
// Notes:   APB slave, zero wait states, unmapped addresses answer pslverr
//          00 control, bit 0 enables corrections
//          04 status, read only: bit 12 stable flag, bits 11:0 control word
//          08 event status, write one to clear
//          0C event mask, same layout as event status
//          10 control word, software load of divider:stage
//          event 0 correction made, 1 stable flag rose
//          event 2 stable flag fell, 3 word past the divider maximum
//          band codes 6 and 7 hold the word and clear the stable flag
//          the word is never clamped; the divider output limits it
// Function
// R1 - drive divider and stage select outputs
// R2 - one 12-bit word, signed step up to 32
// R3 - minus one below nominal, plus one above
// R4 - plus eight between 1.05 and 1.15
// R5 - minus eight, minus/plus thirty-two outer bands
// R6 - stage carry or borrow moves divider nibble
// R7 - no clamping; word may wrap past 9FF
// R8 - divider values A to F act as 9
// R9 - recover by normal corrections, no special case
// R10 - stable flag when error within five percent
// R11 - long count for low-five-bits of 32 cycles
// R12 - upper 011 gives 23 base, 25 long
// R13 - zero fraction never long, all ones 31/32
// R14 - upper 111 alternates 31 and 17 halved
// R15 - one correction per comparator evaluation, synchronous
module clfd_loop_filter
    import clfd_pkg::*;
(
    input  wire logic              pclk,               // bus and filter clock
    input  wire logic              presetn,            // async reset, active low
    input  wire logic              psel,               // apb select
    input  wire logic              penable,            // apb access phase
    input  wire logic              pwrite,             // apb write
    input  wire logic [ADDR_W-1:0] paddr,              // apb byte address
    input  wire logic [31:0]       pwdata,             // apb write data
    output logic      [31:0]       prdata,             // apb read data
    output logic                   pready,             // apb ready
    output logic                   pslverr,            // apb error
    output logic                   irq,                // level interrupt
    input  wire logic [2:0]        cmp_band,           // comparator band code
    input  wire logic              cmp_done,           // toggles per evaluation
    output logic      [DIV_W-1:0]  divider_select,     // decoded divider
    output logic      [STG_W-1:0]  stage_select,       // stage control byte
    output logic                   filter_stable_flag, // within five percent
    output logic      [5:0]        ring_stages,        // stage delays this cycle
    output logic                   ring_halve          // divide-by-two active
);

    typedef enum logic [1:0] {
        CLFD_DIR_HOLD,
        CLFD_DIR_UP,
        CLFD_DIR_DOWN
    } clfd_dir_e;

    typedef enum logic [2:0] {
        CLFD_REG_NONE,
        CLFD_REG_CTRL,
        CLFD_REG_STATUS,
        CLFD_REG_INTSTAT,
        CLFD_REG_INTMASK,
        CLFD_REG_WORD
    } clfd_reg_e;

    logic [2:0]        band_s1;
    logic [2:0]        band_s2;
    logic              done_s1;
    logic              done_s2;
    logic              done_s3;
    logic              eval_pulse;
    logic [WORD_W-1:0] ctl_word;
    logic [WORD_W-1:0] next_word;
    logic [WORD_W-1:0] step;
    clfd_dir_e         dir;
    logic              next_stable;
    logic [31:0]       ctrl;
    logic [EV_W-1:0]   int_stat;
    logic [EV_W-1:0]   int_mask;
    logic [EV_W-1:0]   ev;
    logic [FRAC_W-1:0] dither_acc;
    logic [FRAC_W:0]   dither_sum;
    logic [5:0]        next_stages;
    logic              next_halve;
    logic              wr_en;
    logic              rd_en;
    logic              addr_ok;
    clfd_reg_e         reg_sel;
    logic              ctrl_load;
    logic              mask_load;
    logic              stat_clr;
    logic              word_load;

    // step size per band
    function automatic logic [WORD_W-1:0] band_step(input logic [2:0] b);
        logic [WORD_W-1:0] s;
        s = '0;
        case (b)
            BAND_LT085, BAND_GT115: s = STEP_COARSE;
            BAND_LT095, BAND_LT115: s = STEP_MID;
            BAND_LT100, BAND_LT105: s = STEP_FINE;
            default:                s = '0;
        endcase
        return s;
    endfunction : band_step

    // base stage count from upper stage bits
    function automatic logic [5:0] base_stages(input logic [2:0] u);
        logic [5:0] n;
        n = STG_OFFSET + {2'h0, u, 1'b0};
        return n;
    endfunction : base_stages

    // map a byte address onto a register, or none when unmapped
    function automatic clfd_reg_e reg_decode(input logic [ADDR_W-1:0] a);
        clfd_reg_e r;
        r = CLFD_REG_NONE;
        if (a == OFS_CTRL) begin
            r = CLFD_REG_CTRL;
        end else if (a == OFS_STATUS) begin
            r = CLFD_REG_STATUS;
        end else if (a == OFS_INTSTAT) begin
            r = CLFD_REG_INTSTAT;
        end else if (a == OFS_INTMASK) begin
            r = CLFD_REG_INTMASK;
        end else if (a == OFS_WORD) begin
            r = CLFD_REG_WORD;
        end
        return r;
    endfunction : reg_decode

    // band code from the comparator domain; steady before done toggles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            band_s1 <= 3'h0;
            band_s2 <= 3'h0;
        end else begin
            band_s1 <= cmp_band;
            band_s2 <= band_s1;
        end
    end

    // done toggle: two stages to settle, a third to find the edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_s1 <= 1'b0;
            done_s2 <= 1'b0;
            done_s3 <= 1'b0;
        end else begin
            done_s1 <= cmp_done;
            done_s2 <= done_s1;
            done_s3 <= done_s2;
        end
    end

    // each toggle of the done line marks one finished evaluation
    assign eval_pulse = (done_s2 ^ done_s3) & ctrl[CTRL_EN]; // R15

    always_comb begin
        dir  = CLFD_DIR_HOLD;
        step = band_step(band_s2); // R2
        case (band_s2)
            BAND_LT085: dir = CLFD_DIR_DOWN; // R5
            BAND_LT095: dir = CLFD_DIR_DOWN; // R5
            BAND_LT100: dir = CLFD_DIR_DOWN; // R3
            BAND_LT105: dir = CLFD_DIR_UP;   // R3
            BAND_LT115: dir = CLFD_DIR_UP;   // R4
            BAND_GT115: dir = CLFD_DIR_UP;   // R5
            default:    dir = CLFD_DIR_HOLD;
        endcase
    end

    // plain 12-bit add: stage carry/borrow reaches divider, no clamp
    always_comb begin
        next_word = ctl_word;
        case (dir)
            CLFD_DIR_UP:   next_word = ctl_word + step; // R6 R7
            CLFD_DIR_DOWN: next_word = ctl_word - step; // R6 R7 R9
            default:       next_word = ctl_word;
        endcase
    end

    assign next_stable = (band_s2 == BAND_LT100) || (band_s2 == BAND_LT105); // R10

    assign reg_sel   = reg_decode(paddr);
    assign wr_en     = psel & penable & pwrite & pready;
    assign rd_en     = psel & ~penable & ~pwrite;
    assign addr_ok   = (reg_sel != CLFD_REG_NONE);
    assign ctrl_load = wr_en && (reg_sel == CLFD_REG_CTRL);
    assign mask_load = wr_en && (reg_sel == CLFD_REG_INTMASK);
    assign stat_clr  = wr_en && (reg_sel == CLFD_REG_INTSTAT);
    assign word_load = wr_en && (reg_sel == CLFD_REG_WORD);

    // control word: filter correction or software load
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_word <= WORD_RESET;
        end else if (word_load) begin
            ctl_word <= pwdata[WORD_W-1:0];
        end else if (eval_pulse) begin
            ctl_word <= next_word; // R2 R15
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filter_stable_flag <= 1'b0;
        end else if (eval_pulse) begin
            filter_stable_flag <= next_stable; // R10 R15
        end
    end

    // outputs to the oscillator
    // divider values above nine run as the slowest setting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            divider_select <= WORD_RESET[WORD_W-1:STG_W];
        end else if (ctl_word[WORD_W-1:STG_W] > DIV_SLOW) begin
            divider_select <= DIV_SLOW; // R8
        end else begin
            divider_select <= ctl_word[WORD_W-1:STG_W]; // R1
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage_select <= WORD_RESET[STG_W-1:0];
        end else begin
            stage_select <= ctl_word[STG_W-1:0]; // R1
        end
    end

    // fine adjust: accumulator spreads long cycles over 32
    assign dither_sum = {1'b0, dither_acc} + {1'b0, stage_select[FRAC_W-1:0]}; // R11 R13

    always_comb begin
        next_stages = base_stages(stage_select[STG_W-1:FRAC_W]); // R12
        next_halve  = 1'b0;
        if (dither_sum[FRAC_W]) begin
            if (stage_select[STG_W-1:FRAC_W] == SEL_HALVE) begin
                next_stages = STG_HALVED; // R14
                next_halve  = 1'b1;       // R14
            end else begin
                next_stages = base_stages(stage_select[STG_W-1:FRAC_W]) + STG_LONG_D; // R12
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dither_acc <= '0;
        end else begin
            dither_acc <= dither_sum[FRAC_W-1:0]; // R11
        end
    end

    // one ring cycle per clock: stage count and halving of the next cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ring_stages <= STG_OFFSET;
            ring_halve  <= 1'b0;
        end else begin
            ring_stages <= next_stages;
            ring_halve  <= next_halve;
        end
    end

    // events
    always_comb begin
        ev            = '0;
        ev[EV_STEP]   = eval_pulse && (dir != CLFD_DIR_HOLD);
        ev[EV_LOCK]   = eval_pulse && next_stable && !filter_stable_flag;
        ev[EV_UNLOCK] = eval_pulse && !next_stable && filter_stable_flag;
        ev[EV_RANGE]  = eval_pulse && (next_word > WORD_MAX);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= 32'h0000_0000;
        end else if (ctrl_load) begin
            ctrl <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_mask <= '0;
        end else if (mask_load) begin
            int_mask <= pwdata[EV_W-1:0];
        end
    end

    // set wins over a same-cycle write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat <= '0;
        end else if (stat_clr) begin
            int_stat <= (int_stat & ~pwdata[EV_W-1:0]) | ev;
        end else begin
            int_stat <= int_stat | ev;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_stat & int_mask);
        end
    end

    // apb: ready in every access phase, read data captured at setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel & ~penable;
        end
    end

    // unmapped offsets answer with an error and have no effect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel & ~penable & ~addr_ok;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            if (reg_sel == CLFD_REG_CTRL) begin
                prdata <= ctrl;
            end else if (reg_sel == CLFD_REG_STATUS) begin
                prdata <= {19'h0, filter_stable_flag, ctl_word};
            end else if (reg_sel == CLFD_REG_INTSTAT) begin
                prdata <= {28'h0, int_stat};
            end else if (reg_sel == CLFD_REG_INTMASK) begin
                prdata <= {28'h0, int_mask};
            end else if (reg_sel == CLFD_REG_WORD) begin
                prdata <= {20'h0, ctl_word};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end else if (psel & ~penable) begin
            prdata <= 32'h0000_0000;
        end
    end

endmodule : clfd_loop_filter

/* hdl/clfd_pkg.sv */
// Purpose: constants for the clock loop filter and fine-adjust dither
// Assumes: 32-bit APB, one aligned word per register
// Notes:   comparator band codes are set by the analog front end
package clfd_pkg;
    localparam int         CLK_HZ       = 20_000_000;
    localparam int         WORD_W       = 12;
    localparam int         DIV_W        = 4;
    localparam int         STG_W        = 8;
    localparam int         FRAC_W       = 5;
    localparam int         ADDR_W       = 8;

    // comparator band codes, slowest to fastest base clock
    localparam logic [2:0] BAND_LT085   = 3'h0;
    localparam logic [2:0] BAND_LT095   = 3'h1;
    localparam logic [2:0] BAND_LT100   = 3'h2;
    localparam logic [2:0] BAND_LT105   = 3'h3;
    localparam logic [2:0] BAND_LT115   = 3'h4;
    localparam logic [2:0] BAND_GT115   = 3'h5;

    localparam logic [11:0] STEP_COARSE = 12'h020;
    localparam logic [11:0] STEP_MID    = 12'h008;
    localparam logic [11:0] STEP_FINE   = 12'h001;
    localparam logic [11:0] WORD_MAX    = 12'h9FF;
    localparam logic [11:0] WORD_RESET  = 12'h000;
    localparam logic [3:0]  DIV_SLOW    = 4'h9;

    // ring stage counts
    localparam logic [2:0]  SEL_HALVE   = 3'h7;
    localparam logic [5:0]  STG_OFFSET  = 6'h11;
    localparam logic [5:0]  STG_LONG_D  = 6'h02;
    localparam logic [5:0]  STG_HALVED  = 6'h11;

    // register map (byte addresses)
    localparam logic [7:0]  OFS_CTRL    = 8'h00;
    localparam logic [7:0]  OFS_STATUS  = 8'h04;
    localparam logic [7:0]  OFS_INTSTAT = 8'h08;
    localparam logic [7:0]  OFS_INTMASK = 8'h0C;
    localparam logic [7:0]  OFS_WORD    = 8'h10;

    // ctrl fields
    localparam int          CTRL_EN     = 0;
    // event bit positions
    localparam int          EV_STEP     = 0;
    localparam int          EV_LOCK     = 1;
    localparam int          EV_UNLOCK   = 2;
    localparam int          EV_RANGE    = 3;
    localparam int          EV_W        = 4;
endpackage : clfd_pkg

/* verif/clfd_cmp_model.sv */
// Purpose: comparator side of the loop filter
// Assumes: band settles two edges before done toggles
// Notes:   band drifts to a hold code between evaluations
module clfd_cmp_model
    import clfd_pkg::*;
(
    input  wire logic       pclk,     // clock
    output logic      [2:0] cmp_band, // band code
    output logic            cmp_done  // toggles per evaluation
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        cmp_band = 3'h6;
        cmp_done = 1'b0;
    end
    task automatic evaluate(input logic [2:0] band);
        @(posedge pclk);
        cmp_band <= band;
        repeat (2) @(posedge pclk);
        cmp_done <= ~cmp_done;
        repeat (8) @(posedge pclk);
        cmp_band <= 3'h7;
    endtask : evaluate
endmodule : clfd_cmp_model

/* verif/clfd_loop_filter_props.sv */
// Purpose: port checks of the loop filter
// Assumes: zero wait state bus
// Notes:   counters age the last evaluation and write
module clfd_loop_filter_props
    import clfd_pkg::*;
(
    input wire logic        pclk,        // clock
    input wire logic        presetn,     // reset
    input wire logic        psel,        // select
    input wire logic        penable,     // enable
    input wire logic        pwrite,      // write
    input wire logic [7:0]  paddr,       // address
    input wire logic [31:0] prdata,      // read data
    input wire logic        pready,      // ready
    input wire logic        pslverr,     // error
    input wire logic        cmp_done,    // evaluation toggle
    input wire logic [3:0]  divider_select, // divider
    input wire logic [7:0]  stage_select, // stage byte
    input wire logic        filter_stable_flag, // stable
    input wire logic [5:0]  ring_stages, // stage count
    input wire logic        ring_halve   // halve
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] since_done;
    logic [3:0] since_wr;
    logic       done_q;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_q     <= 1'b0;
            since_done <= 4'hF;
        end else begin
            done_q     <= cmp_done;
            since_done <= (cmp_done != done_q) ? 4'h0 : since_done + {3'h0, since_done != 4'hF};
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) since_wr <= 4'hF;
        else since_wr <= (psel && penable && pwrite && pready) ? 4'h0 : since_wr + {3'h0, since_wr != 4'hF};
    end
    a_div_max: assert property (divider_select <= 4'h9) else $error("divider above nine");
    a_ready_next: assert property (psel && !penable |=> pready) else $error("no ready");
    a_ready_access: assert property (pready |-> psel && penable) else $error("stray ready");
    a_err_data: assert property (pslverr |-> prdata == 32'h0) else $error("error data");
    a_err_map: assert property (psel && !penable && !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10})
        |=> pslverr) else $error("unmapped accepted");
    a_halve_only: assert property ($stable(stage_select) && ring_halve |-> ring_stages == 6'h11
        && stage_select[7:5] == 3'h7) else $error("bad halve");
    a_dither_count: assert property ($stable(stage_select) && !ring_halve |->
        ring_stages == 6'h11 + {2'h0, stage_select[7:5], 1'b0} + {4'h0, stage_select[4:0] != 5'h0, 1'b0}
        || ring_stages == 6'h11 + {2'h0, stage_select[7:5], 1'b0}) else $error("bad count");
    a_step_time: assert property ($changed(stage_select) |-> since_done inside {[1:6]} || since_wr < 4'h3)
        else $error("stray step");
    a_carry_div: assert property ($changed(divider_select) |-> $changed(stage_select) || since_wr < 4'h3)
        else $error("divider without carry");
    a_flag_time: assert property ($changed(filter_stable_flag) |-> since_done inside {[1:6]})
        else $error("stray flag");
endmodule : clfd_loop_filter_props
bind clfd_loop_filter clfd_loop_filter_props clfd_loop_filter_props_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp_done(cmp_done), .divider_select(divider_select), .stage_select(stage_select),
    .filter_stable_flag(filter_stable_flag), .ring_stages(ring_stages), .ring_halve(ring_halve));

/* verif/clfd_loop_filter_tb.sv */
// Purpose: self-checking bench of the loop filter
// Assumes: comparator model drives band and done
// Notes:   expected words come from the step table
module clfd_loop_filter_tb
    import clfd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, cmp_done, filter_stable_flag, ring_halve;
    logic [7:0]  paddr, stage_select;
    logic [31:0] pwdata, prdata, q;
    logic [2:0]  cmp_band;
    logic [3:0]  divider_select;
    logic [5:0]  ring_stages;
    logic        e;
    int          n_mismatch = 0;
    int          checked = 0;
    logic [11:0] steps [8] = '{12'hFE0, 12'hFF8, 12'hFFF, 12'h001, 12'h008, 12'h020, 12'h000, 12'h000};
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    clfd_loop_filter clfd_loop_filter_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .cmp_band(cmp_band), .cmp_done(cmp_done), .divider_select(divider_select),
        .stage_select(stage_select), .filter_stable_flag(filter_stable_flag), .ring_stages(ring_stages),
        .ring_halve(ring_halve));
    clfd_cmp_model clfd_cmp_model_i (.pclk(pclk), .cmp_band(cmp_band), .cmp_done(cmp_done));
    task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb_xfer
    task automatic chk(input string nm, input logic [32:0] got, input logic [32:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk
    task automatic step(input logic [11:0] w, input logic [2:0] b);
        logic [11:0] x;
        x = w + steps[b];
        apb_xfer(1'b1, OFS_WORD, {20'h0, w});
        clfd_cmp_model_i.evaluate(b);
        apb_xfer(1'b0, OFS_STATUS, 32'h0);
        chk("word", q[11:0], x);
        chk("flag", {q[12], filter_stable_flag}, {2{(b == 3'h2) || (b == 3'h3)}});
        chk("div", divider_select, x[11:8] > 4'h9 ? 4'h9 : x[11:8]);
        chk("stage", stage_select, x[7:0]);
    endtask : step
    task automatic dith(input logic [11:0] w, input logic [5:0] bs, input logic [5:0] lg, input logic hv, input int nl);
        int n_l;
        int n_b;
        n_l = 0;
        n_b = 0;
        apb_xfer(1'b1, OFS_WORD, {20'h0, w});
        repeat (4) @(posedge pclk);
        repeat (32) begin
            @(negedge pclk);
            if (ring_stages === lg && ring_halve === hv) n_l++;
            else if (ring_stages === bs && ring_halve === 1'b0) n_b++;
        end
        chk("dither", {n_l[15:0], n_b[15:0]}, {nl[15:0], 16'(32 - nl)});
    endtask : dith
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        final_report();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk("reset", {ring_stages, divider_select, stage_select, filter_stable_flag, irq}, {6'h11, 14'h0});
        apb_xfer(1'b0, 8'h14, 32'h0);
        chk("unmapped", {e, q}, {1'b1, 32'h0});
        apb_xfer(1'b1, OFS_CTRL, 32'h1);
        apb_xfer(1'b1, OFS_INTMASK, 32'h0);
        for (int b = 0; b < 8; b++) step(12'h100, b[2:0]);
        step(12'h9FF, 3'h5);
        step(12'h000, 3'h1);
        step(12'hA1F, 3'h0);
        $display("test steps done");
        apb_xfer(1'b1, OFS_CTRL, 32'h0);
        apb_xfer(1'b1, OFS_WORD, 32'h123);
        clfd_cmp_model_i.evaluate(3'h5);
        apb_xfer(1'b0, OFS_STATUS, 32'h0);
        chk("disabled", q[11:0], 12'h123);
        apb_xfer(1'b1, OFS_CTRL, 32'h1);
        apb_xfer(1'b1, OFS_INTSTAT, 32'hF);
        step(12'h100, 3'h3);
        chk("irq masked", irq, 1'b0);
        apb_xfer(1'b0, OFS_INTSTAT, 32'h0);
        chk("event", q, 32'h3);
        apb_xfer(1'b1, OFS_INTMASK, 32'h1);
        apb_xfer(1'b0, OFS_INTMASK, 32'h0);
        chk("irq on", {irq, q}, {1'b1, 32'h1});
        apb_xfer(1'b1, OFS_INTSTAT, 32'h1);
        apb_xfer(1'b0, OFS_INTSTAT, 32'h0);
        chk("irq off", {irq, q[0]}, 2'h0);
        step(12'h9FF, 3'h5);
        apb_xfer(1'b0, OFS_INTSTAT, 32'h0);
        chk("events all", {irq, q}, {1'b1, 32'hF});
        $display("test interrupt done");
        dith(12'h060, 6'h17, 6'h19, 1'b0, 0);
        dith(12'h07F, 6'h17, 6'h19, 1'b0, 31);
        dith(12'h0E1, 6'h1F, 6'h11, 1'b1, 1);
        dith(12'h0FF, 6'h1F, 6'h11, 1'b1, 31);
        $display("test dither done");
        final_report();
    end
endmodule : clfd_loop_filter_tb
